// [pio_defines.svh]
/*
 * register offsets, reset values and option codes for the parallel io port.
 * assumes a 32-bit register bus with one aligned word per register.
 */
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// printed register indices; byte address is four times the index
`define PIO_IDX_DATA      3'h0
`define PIO_IDX_DIR       3'h1
`define PIO_IDX_IRQ_MASK  3'h2
`define PIO_IDX_EDGE_CAP  3'h3
`define PIO_IDX_OUT_SET   3'h4
`define PIO_IDX_OUT_CLR   3'h5

// reset values of software-visible control state
`define PIO_DIR_RST       32'h0000_0000
`define PIO_MASK_RST      32'h0000_0000
`define PIO_CAP_RST       32'h0000_0000

// value returned for absent or unmapped registers
`define PIO_UNDEF_RD      32'h0000_0000

// axi response codes
`define PIO_RESP_OKAY     2'h0
`define PIO_RESP_SLVERR   2'h2

// direction configuration codes
`define PIO_DIR_IN        2'h0
`define PIO_DIR_OUT       2'h1
`define PIO_DIR_BIDIR     2'h2

// edge type codes
`define PIO_EDGE_RISE     2'h0
`define PIO_EDGE_FALL     2'h1
`define PIO_EDGE_ANY      2'h2

`endif

// [pio_pkg.sv]
/*
 * types shared by the parallel io port files.
 * assumes pio_defines.svh is on the include path.
 */
package pio_pkg;

   // register word index on the bus
   typedef logic [2:0] pio_idx_t;

   // slave state: idle, or holding an answer
   typedef enum logic [0:0] {
      PIO_ST_IDLE,
      PIO_ST_RESP
   } pio_bus_st_t;

endpackage

// [pio_edge_det.sv]
/*
 * edge detector for the parallel io port: compares each input sample with
 * the previous cycle's sample. assumes inputs already synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

`include "pio_defines.svh"

module pio_edge_det #(
   parameter int         WIDTH     = 32,
   parameter logic [1:0] EDGE_TYPE = `PIO_EDGE_RISE
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // sampled inputs
   input  wire logic [WIDTH-1:0] in_i,
   // one-cycle edge pulses
   output logic      [WIDTH-1:0] edge_o
);

   logic [WIDTH-1:0] prev_r;   // previous-cycle sample

   ////////////////////////////////////////////////////////////////////////
   // previous sample; zero after reset so a high input counts as a rise
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_r <= '0;
      end else begin
         prev_r <= in_i;
      end
   end

   // pair compare per configured type, fixed at build time
   always_comb begin
      if (EDGE_TYPE == `PIO_EDGE_RISE) begin
         edge_o = in_i & ~prev_r;
      end else if (EDGE_TYPE == `PIO_EDGE_FALL) begin
         edge_o = ~in_i & prev_r;
      end else begin
         edge_o = in_i ^ prev_r;
      end
   end

endmodule

`default_nettype wire

// [pio_port.sv]
/*
 * parallel io port: 1 to 32 ports with data, direction, interrupt mask,
 * edge capture and set/clear registers behind an axi4-lite slave.
 * assumes port inputs are synchronous to clk_i and the bus master keeps
 * at most one read and one write outstanding.
 */
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "pio_defines.svh"

// Overview of operation
// - port width fixed between 1 and 32
// - input, output or bidirectional build options
// - direction register tristates bidirectional pins
// - data read returns live input ports
// - data write loads separate output register
// - edge type fixed at build time
// - detected edge sets sticky capture bit
// - capture register only when capture option chosen
// - bit-clear mode: written ones clear bits
// - level interrupts sense high inputs only
// - level mode: high input and enable
// - edge mode: capture bit and enable
// - one interrupt enable bit per port
// - one register slave plus interrupt output
// - output register loads build-time reset value
// - optional set and clear write registers
// - no capture or interrupts when output-only
// - without bit-clear any write clears all
// - bidirectional port drives when direction one
// - direction resets to zero, pins input
// - edge interrupt holds until mask or capture written
module pio_port
   import pio_pkg::*;
#(
   parameter int                WIDTH       = 32,
   parameter logic [1:0]        DIR_MODE    = `PIO_DIR_BIDIR,
   parameter logic [WIDTH-1:0]  OUT_RST     = '0,
   parameter bit                HAS_SETCLR  = 1'b1,
   parameter bit                HAS_CAPTURE = 1'b1,
   parameter logic [1:0]        EDGE_TYPE   = `PIO_EDGE_RISE,
   parameter bit                BIT_CLEAR   = 1'b1,
   parameter bit                HAS_IRQ     = 1'b1,
   parameter bit                IRQ_EDGE    = 1'b1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // axi4-lite write address
   input  wire logic [31:0]      s_axi_awaddr_i,
   input  wire logic             s_axi_awvalid_i,
   output logic                  s_axi_awready_o,
   // axi4-lite write data
   input  wire logic [31:0]      s_axi_wdata_i,
   input  wire logic [3:0]       s_axi_wstrb_i,
   input  wire logic             s_axi_wvalid_i,
   output logic                  s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]            s_axi_bresp_o,
   output logic                  s_axi_bvalid_o,
   input  wire logic             s_axi_bready_i,
   // axi4-lite read address
   input  wire logic [31:0]      s_axi_araddr_i,
   input  wire logic             s_axi_arvalid_i,
   output logic                  s_axi_arready_o,
   // axi4-lite read data
   output logic [31:0]           s_axi_rdata_o,
   output logic [1:0]            s_axi_rresp_o,
   output logic                  s_axi_rvalid_o,
   input  wire logic             s_axi_rready_i,
   // port pins
   input  wire logic [WIDTH-1:0] port_in_i,
   output logic      [WIDTH-1:0] port_out_o,
   output logic      [WIDTH-1:0] port_oe_o,
   // interrupt request
   output logic                  irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // build-time features
   localparam bit HAS_IN   = (DIR_MODE != `PIO_DIR_OUT);
   localparam bit HAS_OUT  = (DIR_MODE != `PIO_DIR_IN);
   localparam bit HAS_DIR  = (DIR_MODE == `PIO_DIR_BIDIR);
   localparam bit CAP_ON   = HAS_CAPTURE && HAS_IN;
   localparam bit IRQ_ON   = HAS_IRQ && HAS_IN;
   localparam bit IRQ_EDGE_ON = IRQ_EDGE && CAP_ON;          // edge irq needs capture

   // static check of the width range
   initial begin
      if (WIDTH < 1 || WIDTH > 32) begin
         $error("port width outside 1 to 32");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [WIDTH-1:0] out_r;      // output-drive register
   logic [WIDTH-1:0] dir_r;      // per-port direction, 1 = drive
   logic [WIDTH-1:0] mask_r;     // per-port interrupt enable
   logic [WIDTH-1:0] cap_r;      // sticky edge capture
   logic [WIDTH-1:0] edge_hit;   // edge pulses from detector

   // bus state
   pio_bus_st_t      wr_st_r;    // write answer pending
   pio_bus_st_t      rd_st_r;    // read answer pending
   logic             aw_got_r;   // write address held
   logic             w_got_r;    // write data held
   logic [31:0]      awaddr_r;   // held write address
   logic [31:0]      wdata_r;    // held write data
   logic [3:0]       wstrb_r;    // held byte strobes
   logic [1:0]       bresp_r;    // write response code
   logic [31:0]      rdata_r;    // read data
   logic [1:0]       rresp_r;    // read response code

   // decoded write strobes, one cycle each
   logic             wr_fire;
   pio_idx_t         wr_idx;
   logic [31:0]      wr_val;
   logic             wr_ok;

   ////////////////////////////////////////////////////////////////////////
   // address decode: index of an aligned word within the eight-word window
   function automatic pio_idx_t addr_idx(input logic [31:0] addr);
      addr_idx = addr[4:2];
   endfunction

   // merge a write under byte strobes onto an old value
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      strb_merge = res;
   endfunction

   // is this index present in the current build
   function automatic logic idx_present(input pio_idx_t idx);
      if (idx == `PIO_IDX_DATA) begin
         idx_present = 1'b1;
      end else if (idx == `PIO_IDX_DIR) begin
         idx_present = HAS_DIR;
      end else if (idx == `PIO_IDX_IRQ_MASK) begin
         idx_present = IRQ_ON;
      end else if (idx == `PIO_IDX_EDGE_CAP) begin
         idx_present = CAP_ON;
      end else if (idx == `PIO_IDX_OUT_SET || idx == `PIO_IDX_OUT_CLR) begin
         idx_present = HAS_SETCLR && HAS_OUT;
      end else begin
         idx_present = 1'b0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write channel capture; address and data accepted in either order
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
         end else if (wr_fire) begin
            aw_got_r <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end else if (wr_fire) begin
            w_got_r <= 1'b0;
         end
      end
   end

   // ready while the channel's item is not yet held and no answer waits
   assign s_axi_awready_o = !aw_got_r && (wr_st_r == PIO_ST_IDLE);
   assign s_axi_wready_o  = !w_got_r && (wr_st_r == PIO_ST_IDLE);

   // both halves held: perform the write this cycle
   assign wr_fire = aw_got_r && w_got_r && (wr_st_r == PIO_ST_IDLE);
   assign wr_idx  = addr_idx(awaddr_r);
   assign wr_ok   = (awaddr_r[31:5] == '0) && idx_present(wr_idx);
   assign wr_val  = strb_merge(32'h0000_0000, wdata_r, wstrb_r);

   // write answer; absent registers ignore the write, answer slverr
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_st_r <= PIO_ST_IDLE;
         bresp_r <= `PIO_RESP_OKAY;
      end else begin
         case (wr_st_r)
            PIO_ST_IDLE: begin
               if (wr_fire) begin
                  wr_st_r <= PIO_ST_RESP;
                  bresp_r <= wr_ok ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
               end
            end
            default: begin
               if (s_axi_bready_i) begin
                  wr_st_r <= PIO_ST_IDLE;
               end
            end
         endcase
      end
   end

   assign s_axi_bvalid_o = (wr_st_r == PIO_ST_RESP);
   assign s_axi_bresp_o  = bresp_r;

   ////////////////////////////////////////////////////////////////////////
   // output-drive register: data write, set and clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_r <= OUT_RST;
      end else if (wr_fire && wr_ok && HAS_OUT) begin
         if (wr_idx == `PIO_IDX_DATA) begin
            // byte strobes keep unwritten lanes of the output register
            out_r <= WIDTH'(strb_merge(32'(out_r), wdata_r, wstrb_r));
         end else if (wr_idx == `PIO_IDX_OUT_SET) begin
            out_r <= out_r | wr_val[WIDTH-1:0];
         end else if (wr_idx == `PIO_IDX_OUT_CLR) begin
            out_r <= out_r & ~wr_val[WIDTH-1:0];
         end
      end
   end

   // direction register, bidirectional builds only
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dir_r <= WIDTH'(`PIO_DIR_RST);
      end else if (HAS_DIR && wr_fire && wr_ok && wr_idx == `PIO_IDX_DIR) begin
         dir_r <= WIDTH'(strb_merge(32'(dir_r), wdata_r, wstrb_r));
      end
   end

   // interrupt enable register, only with interrupts built
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_r <= WIDTH'(`PIO_MASK_RST);
      end else if (IRQ_ON && wr_fire && wr_ok && wr_idx == `PIO_IDX_IRQ_MASK) begin
         mask_r <= WIDTH'(strb_merge(32'(mask_r), wdata_r, wstrb_r));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // edge detection on the synchronous input samples
   pio_edge_det #(
      .WIDTH     (WIDTH),
      .EDGE_TYPE (EDGE_TYPE)
   ) u_edge (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .in_i   (port_in_i),
      .edge_o (edge_hit)
   );

   // sticky capture; a new edge wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cap_r <= WIDTH'(`PIO_CAP_RST);
      end else if (CAP_ON) begin
         if (wr_fire && wr_ok && wr_idx == `PIO_IDX_EDGE_CAP) begin
            if (BIT_CLEAR) begin
               cap_r <= (cap_r & ~wr_val[WIDTH-1:0]) | edge_hit;
            end else begin
               cap_r <= edge_hit;
            end
         end else begin
            cap_r <= cap_r | edge_hit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins: drive only when the port is an output
   always_comb begin
      port_out_o = HAS_OUT ? out_r : '0;
      if (HAS_DIR) begin
         port_oe_o = dir_r;
      end else if (HAS_OUT) begin
         port_oe_o = '1;
      end else begin
         port_oe_o = '0;
      end
   end

   // interrupt: level from live inputs or edge from capture, masked
   always_comb begin
      if (!IRQ_ON) begin
         irq_o = 1'b0;
      end else if (IRQ_EDGE_ON) begin
         irq_o = |(cap_r & mask_r);
      end else begin
         irq_o = |(port_in_i & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path: one register stage, reads see live inputs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_st_r <= PIO_ST_IDLE;
         rdata_r <= '0;
         rresp_r <= `PIO_RESP_OKAY;
      end else begin
         case (rd_st_r)
            PIO_ST_IDLE: begin
               if (s_axi_arvalid_i) begin
                  rd_st_r <= PIO_ST_RESP;
                  rresp_r <= (s_axi_araddr_i[31:5] == '0 &&
                              idx_present(addr_idx(s_axi_araddr_i)))
                             ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
                  rdata_r <= `PIO_UNDEF_RD;
                  if (s_axi_araddr_i[31:5] == '0) begin
                     if (addr_idx(s_axi_araddr_i) == `PIO_IDX_DATA && HAS_IN) begin
                        rdata_r <= 32'(port_in_i);
                     end else if (addr_idx(s_axi_araddr_i) == `PIO_IDX_DIR && HAS_DIR) begin
                        rdata_r <= 32'(dir_r);
                     end else if (addr_idx(s_axi_araddr_i) == `PIO_IDX_IRQ_MASK && IRQ_ON) begin
                        rdata_r <= 32'(mask_r);
                     end else if (addr_idx(s_axi_araddr_i) == `PIO_IDX_EDGE_CAP && CAP_ON) begin
                        rdata_r <= 32'(cap_r);
                     end
                  end
               end
            end
            default: begin
               if (s_axi_rready_i) begin
                  rd_st_r <= PIO_ST_IDLE;
               end
            end
         endcase
      end
   end

   assign s_axi_arready_o = (rd_st_r == PIO_ST_IDLE);
   assign s_axi_rvalid_o  = (rd_st_r == PIO_ST_RESP);
   assign s_axi_rdata_o   = rdata_r;
   assign s_axi_rresp_o   = rresp_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_edge_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
      CAP_ON && $past(edge_hit) != '0 |-> (cap_r & $past(edge_hit)) == $past(edge_hit))
      else $error("captured edge lost");
   a_capture_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
      CAP_ON && !$past(wr_fire) |-> (cap_r & $past(cap_r)) == $past(cap_r))
      else $error("capture bit dropped without write");
   a_clear_all: assert property (@(posedge clk_i) disable iff (!rstn_i)
      CAP_ON && !BIT_CLEAR && wr_fire && wr_ok && wr_idx == `PIO_IDX_EDGE_CAP
      |=> cap_r == $past(edge_hit))
      else $error("capture not cleared by write");
   a_bit_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
      CAP_ON && BIT_CLEAR && wr_fire && wr_ok && wr_idx == `PIO_IDX_EDGE_CAP
      |=> cap_r == (($past(cap_r) & ~$past(wr_val[WIDTH-1:0])) | $past(edge_hit)))
      else $error("bit clear wrong");
   a_set_or: assert property (@(posedge clk_i) disable iff (!rstn_i)
      HAS_SETCLR && HAS_OUT && wr_fire && wr_ok && wr_idx == `PIO_IDX_OUT_SET
      |=> out_r == ($past(out_r) | $past(wr_val[WIDTH-1:0])))
      else $error("set register wrong");
   a_clr_and: assert property (@(posedge clk_i) disable iff (!rstn_i)
      HAS_SETCLR && HAS_OUT && wr_fire && wr_ok && wr_idx == `PIO_IDX_OUT_CLR
      |=> out_r == ($past(out_r) & ~$past(wr_val[WIDTH-1:0])))
      else $error("clear register wrong");
   a_oe_dir: assert property (@(posedge clk_i) disable iff (!rstn_i)
      HAS_DIR |-> port_oe_o == dir_r)
      else $error("output enable differs from direction");
   a_irq_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
      irq_o |-> IRQ_ON && ((IRQ_EDGE_ON && (cap_r & mask_r) != '0)
                        || (!IRQ_EDGE_ON && (port_in_i & mask_r) != '0)))
      else $error("interrupt without cause");
   a_read_data: assert property (@(posedge clk_i) disable iff (!rstn_i)
      HAS_IN && rd_st_r == PIO_ST_IDLE && s_axi_arvalid_i && s_axi_araddr_i == 32'h0000_0000
      |=> s_axi_rvalid_o && s_axi_rdata_o == 32'($past(port_in_i)))
      else $error("data read not live input");

   c_edge_irq: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));
   c_write: cover property (@(posedge clk_i) disable iff (!rstn_i) s_axi_bvalid_o && s_axi_bready_i);
   c_read: cover property (@(posedge clk_i) disable iff (!rstn_i) s_axi_rvalid_o && s_axi_rready_i);
   c_cap_clear: cover property (@(posedge clk_i) disable iff (!rstn_i) $fell(|cap_r));

endmodule

`default_nettype wire

// [pio_pin_model.sv]
/* pin model for the parallel io port: resolves every pin from the port's
   output enable and an outside driver. assumes one clock, clk_i. */
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model #(
   parameter int WIDTH = 32
) (
   // clock
   input  wire logic             clk_i,
   // device side
   input  wire logic [WIDTH-1:0] out_i,
   input  wire logic [WIDTH-1:0] oe_i,
   // outside driver
   input  wire logic [WIDTH-1:0] ext_val_i,
   input  wire logic [WIDTH-1:0] ext_drv_i,
   // resolved pins
   output logic      [WIDTH-1:0] pin_o
);
   ////////////////////////////////////////////////////////////
   logic [WIDTH-1:0] float_r = '0; // level of undriven pins
   // undriven pins wander every cycle, so a stale level never passes
   always_ff @(posedge clk_i) begin
      float_r <= ~float_r;
   end
   // resolution; two drivers give x so contention cannot pass unseen
   always_comb begin
      for (int b = 0; b < WIDTH; b++) begin
         case ({oe_i[b], ext_drv_i[b]})
            2'b10:   pin_o[b] = out_i[b];
            2'b01:   pin_o[b] = ext_val_i[b];
            2'b11:   pin_o[b] = 1'bx;
            default: pin_o[b] = float_r[b];
         endcase
      end
   end
endmodule
`default_nettype wire

// [pio_port_test.sv]
/* self-checking bench for the parallel io port over axi4-lite.
   assumes default build: 32 bidir ports, rising capture, edge irq. */
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"
module pio_port_test;
   localparam logic [31:0] RST_V = 32'h0000_00A5; // output reset value
   localparam logic [31:0] P     = 32'hA5A5_0F0F; // outside pin pattern
   logic        clk_i, rstn_i;                  // clock and reset
   logic [31:0] awaddr, wdata, araddr;          // bus requests
   logic [3:0]  wstrb;                          // write strobes
   logic        awvalid, wvalid, bready, arvalid, rready;
   wire         awready, wready, bvalid, arready, rvalid, irq;
   wire  [1:0]  bresp, rresp;                   // response codes
   wire  [31:0] rdata, pout, poe, pin;          // read data and pins
   logic [31:0] ext_val, ext_drv;               // outside driver
   int          n_mismatch, n_checks, cyc;      // verdict counters
   ////////////////////////////////////////////////////////////
   pio_port #(.OUT_RST(RST_V)) dut (
      .clk_i(clk_i), .rstn_i(rstn_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .port_in_i(pin), .port_out_o(pout), .port_oe_o(poe), .irq_o(irq));
   pio_pin_model #(.WIDTH(32)) pins (
      .clk_i(clk_i), .out_i(pout), .oe_i(poe),
      .ext_val_i(ext_val), .ext_drv_i(ext_drv), .pin_o(pin));
   ////////////////////////////////////////////////////////////
   // clock, 25 ns period
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // hang guard: far beyond the hundred or so cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   function automatic logic [31:0] ad(input logic [2:0] i);
      return {27'h0, i, 2'h0};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // write: readies sampled at the falling edge, acted on at the rising one
   task automatic wr(input logic [2:0] i, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, tb, dn;
      logic [1:0] r;
      @(posedge clk_i);
      awaddr <= ad(i); awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      dn = 1'b0;
      while (!dn) begin
         @(negedge clk_i);
         ta = awvalid && awready; tw = wvalid && wready; tb = bvalid && bready; r = bresp;
         @(posedge clk_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            dn = 1'b1;
         end
      end
      chk(32'(r), 32'(er));
   endtask
   // read with expected data and response
   task automatic rd(input logic [2:0] i, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr, dn;
      logic [31:0] v;
      logic [1:0] r;
      @(posedge clk_i);
      araddr <= ad(i); arvalid <= 1'b1; rready <= 1'b1;
      dn = 1'b0;
      while (!dn) begin
         @(negedge clk_i);
         ta = arvalid && arready; tr = rvalid && rready; v = rdata; r = rresp;
         @(posedge clk_i);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            dn = 1'b1;
         end
      end
      chk(v, ed);
      chk(32'(r), 32'(er));
   endtask
   // reset values at the pins and in the registers
   task automatic t_reset();
      @(negedge clk_i);
      chk(pout, RST_V);
      chk(poe, 32'h0);
      chk(32'(irq), 32'h0);
      rd(`PIO_IDX_DIR, `PIO_DIR_RST, `PIO_RESP_OKAY);
      rd(`PIO_IDX_IRQ_MASK, `PIO_MASK_RST, `PIO_RESP_OKAY);
   endtask
   // data reads the pins, writes only the output register, strobes merge
   task automatic t_data();
      ext_val <= P;
      wr(`PIO_IDX_DATA, 32'h1234_5678, 4'hF, `PIO_RESP_OKAY);
      wr(`PIO_IDX_DATA, 32'hFFFF_FFFF, 4'h1, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(pout, 32'h1234_56FF);
      rd(`PIO_IDX_DATA, P, `PIO_RESP_OKAY);
   endtask
   // clear then set leaves other output bits alone
   task automatic t_setclr();
      wr(`PIO_IDX_OUT_CLR, 32'h0000_0048, 4'hF, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(pout, 32'h1234_56B7);
      wr(`PIO_IDX_OUT_SET, 32'h0000_0040, 4'hF, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(pout, 32'h1234_56F7);
   endtask
   // rising-only capture, sticky bits, per-bit clear, irq masking
   task automatic t_edge();
      wr(`PIO_IDX_EDGE_CAP, 32'hFFFF_FFFF, 4'hF, `PIO_RESP_OKAY);
      rd(`PIO_IDX_EDGE_CAP, 32'h0, `PIO_RESP_OKAY);
      ext_val <= P ^ 32'h0000_0021; // bit 0 falls, bit 5 rises
      repeat (3) @(posedge clk_i);
      rd(`PIO_IDX_EDGE_CAP, 32'h0000_0020, `PIO_RESP_OKAY);
      ext_val <= P | 32'h0000_0020; // bit 0 rises again
      repeat (3) @(posedge clk_i);
      rd(`PIO_IDX_EDGE_CAP, 32'h0000_0021, `PIO_RESP_OKAY);
      wr(`PIO_IDX_IRQ_MASK, 32'h0000_0001, 4'hF, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(32'(irq), 32'h1);
      wr(`PIO_IDX_EDGE_CAP, 32'h0000_0001, 4'hF, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(32'(irq), 32'h0);
      rd(`PIO_IDX_EDGE_CAP, 32'h0000_0020, `PIO_RESP_OKAY);
      wr(`PIO_IDX_IRQ_MASK, 32'hFFFF_FF20, 4'h3, `PIO_RESP_OKAY);
      rd(`PIO_IDX_IRQ_MASK, 32'h0000_FF20, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(32'(irq), 32'h1);
      wr(`PIO_IDX_EDGE_CAP, 32'h0000_0020, 4'hF, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(32'(irq), 32'h0);
   endtask
   // unmapped places refuse with an error code
   task automatic t_unmapped();
      wr(3'h6, 32'hFFFF_FFFF, 4'hF, `PIO_RESP_SLVERR);
      rd(3'h7, `PIO_UNDEF_RD, `PIO_RESP_SLVERR);
   endtask
   // direction one drives the low byte, the rest stay inputs
   task automatic t_dir();
      ext_drv <= 32'hFFFF_FF00;
      wr(`PIO_IDX_DIR, 32'h0000_00FF, 4'hF, `PIO_RESP_OKAY);
      @(negedge clk_i);
      chk(poe, 32'h0000_00FF);
      rd(`PIO_IDX_DATA, 32'hA5A5_0FF7, `PIO_RESP_OKAY);
      rd(`PIO_IDX_DIR, 32'h0000_00FF, `PIO_RESP_OKAY);
   endtask
   // main sequence
   initial begin
      rstn_i = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0;
      bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
      ext_val = '0; ext_drv = 32'hFFFF_FFFF; n_mismatch = 0; n_checks = 0; cyc = 0;
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_data();
      t_setclr();
      t_edge();
      t_unmapped();
      t_dir();
      summarize();
   end
endmodule
`default_nettype wire
